// [exc_entry_defs.vh]
`ifndef EXC_ENTRY_DEFS_VH
`define EXC_ENTRY_DEFS_VH

// Register indices; the byte address on the bus is four times the index.
`define IDX_SYSTEM_CONTROL 16'hfff2
`define IDX_IRQ_SENSE_CONTROL 16'hfff4
`define IDX_IRQ_ENABLE 16'hfff5
`define IDX_IRQ_REQUEST_FLAGS 16'hfff6
`define IDX_PRIORITY_LEVEL_A 16'hfff8
`define IDX_PRIORITY_LEVEL_B 16'hfff9

// Reset values.
`define RST_SYSTEM_CONTROL 8'h0b
`define RST_IRQ_SENSE_CONTROL 8'h00
`define RST_IRQ_ENABLE 8'h00
`define RST_IRQ_REQUEST_FLAGS 8'h00
`define RST_PRIORITY_LEVEL_A 8'h00
`define RST_PRIORITY_LEVEL_B 8'h00

// Field positions.
`define SYSC_USER_BIT_SELECT 3
`define SYSC_NONMASKABLE_EDGE_SELECT 2
`define CCR_GLOBAL_MASK 7
`define CCR_USER_MASK 6

// Vector numbers and vector table.
`define VEC_RESET 6'h00
`define VEC_NONMASKABLE 6'h07
`define VEC_TRAP_BASE 6'h08
`define VEC_EXT_BASE 6'h0c
`define VEC_INT_BASE 6'h14
`define RESET_VECTOR_ADDR 24'h000000

// Timing: power-up hold is kept by the system; the operating hold is also
// used as the length of the internal reset after a watchdog overflow.
`define RST_POWERUP_MS 20
`define RST_HOLD_CYCLES 4'ha
`define CLK_PERIOD_NS 10

`endif

// [reset_trap_interrupt_entry.v]
// Functional notes
// RULE1 - Reset input low halts all processing; reset outranks every other exception.
// RULE2 - Reset exception handling begins on the reset input's low-to-high transition.
// RULE3 - Watchdog overflow resets the device just like the reset input.
// RULE4 - System holds reset input low at least 20 ms at power-up.
// RULE5 - System holds reset input low at least 10 clocks during operation.
// RULE6 - Leaving reset initializes all state and sets the global mask bit.
// RULE7 - After reset, read vector at 0000-0003 and start execution there.
// RULE8 - Right after reset all interrupts, even nonmaskable, wait for first instruction.
// RULE9 - Software should load the stack pointer with the first instruction.
// RULE10 - Accept seven external sources and thirty internal peripheral sources.
// RULE11 - Each source has its own vector address.
// RULE12 - Nonmaskable request is highest, always accepted, edge selectable.
// RULE13 - Two priority levels per module via two priority registers; arbitrate.
// RULE14 - Three-level masking from global mask and user mask bits.
// RULE15 - Each request pin selects falling edge or low level sensing.
// RULE16 - Trap sets global mask; also user mask when user-bit select is 0.
// RULE17 - Trap vector chosen by instruction-encoded number 0 to 3.
// RULE18 - Word and longword accesses, stack included, force address bit 0 low.
// RULE19 - Software keeps stack pointer even and uses word or longword stack access.
// RULE20 - Request flags clear only by writing 0; writing 1 sets nothing. Code also clears an edge-sensed flag when its interrupt is accepted.
// RULE21 - Watchdog overflow and refresh compare match raise interval interrupts.
// RULE22 - Entry pushes PC and flags, sets mask, jumps via vector; reset skips push.
// RULE23 - Interrupts taken at instruction boundaries; reset over interrupts over trap.
// RULE24 - User mask is a mask when select is 0, plain bit at 1; resets 1.
// RULE25 - Nonmaskable edge select 0 is falling edge, 1 rising; resets 0.
// RULE26 - Equal-level simultaneous requests resolve to the lower vector number.
//
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/10ps
`include "exc_entry_defs.vh"

module reset_trap_interrupt_entry (
	// Clock and reset input
	input wire hclk,
	input wire hresetn,
	// AHB-Lite slave
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg hreadyout,
	output reg [31:0] hrdata,
	output reg hresp,
	// Interrupt sources
	input wire nmi_pin,
	input wire [5:0] ext_request_pins_n,
	input wire watchdog_overflow,
	input wire watchdog_interval_tick,
	input wire refresh_match_tick,
	input wire [27:0] periph_req,
	// CPU core side
	input wire cpu_insn_done,
	input wire cpu_trap,
	input wire [1:0] cpu_trap_vec,
	input wire ccr_wr,
	input wire [7:0] ccr_wdata,
	input wire [5:0] ccr_low,
	input wire [23:0] program_counter,
	input wire [31:0] stack_pointer,
	output reg core_hold,
	output reg ccr_global_mask,
	output reg user_mask_bit,
	output reg pc_load,
	output reg [23:0] pc_value,
	output reg sp_load,
	output reg [31:0] sp_value,
	output reg [5:0] vector_number,
	// Memory port for stacking and vector fetch
	output reg mem_req,
	output reg mem_we,
	output reg [23:0] mem_addr,
	output reg [31:0] mem_wdata,
	input wire mem_ack,
	input wire [31:0] mem_rdata
);

	localparam ST_HOLD = 6'h01;
	localparam ST_RVEC = 6'h02;
	localparam ST_FIRST = 6'h04;
	localparam ST_RUN = 6'h08;
	localparam ST_PUSH = 6'h10;
	localparam ST_VEC = 6'h20;
	reg [5:0] st;
	reg [3:0] hold_cnt;
	reg [7:0] system_control;
	reg [7:0] irq_sense_control;
	reg [7:0] irq_enable;
	reg [5:0] irq_request_flags;
	reg [7:0] priority_level_a;
	reg [7:0] priority_level_b;
	reg nmi_prev;
	reg nmi_flag;
	reg [5:0] pins_prev;
	reg wdt_flag;
	reg ref_flag;
	reg trap_pend;
	reg [1:0] trap_vec;
	reg bus_pend;
	reg bus_write;
	reg [15:0] bus_idx;
	reg bus_ok;
	reg [5:0] best_hi;
	reg [5:0] best_lo;
	reg found_hi;
	reg found_lo;
	reg int_take;
	reg [5:0] int_src;
	reg [7:0] rd_val;
	reg [5:0] ack_clear;
	integer i;
	wire reinit = st[0];
	wire ue = system_control[`SYSC_USER_BIT_SELECT];
	wire nonmaskable_edge_select = system_control[`SYSC_NONMASKABLE_EDGE_SELECT];
	wire nmi_edge = nonmaskable_edge_select ? (nmi_pin & ~nmi_prev) : (~nmi_pin & nmi_prev); // RULE25
	wire [5:0] pin_fall = pins_prev & ~ext_request_pins_n;
	// Sense bit 1 selects falling edge, 0 selects low level.
	wire [5:0] pin_set = (irq_sense_control[5:0] & pin_fall) |
		(~irq_sense_control[5:0] & ~ext_request_pins_n); // RULE15
	wire [35:0] pend = {periph_req, ref_flag, wdt_flag,
		irq_request_flags & irq_enable[5:0]}; // RULE10
	wire [35:0] lvl = {priority_level_b[1], {4{priority_level_b[2]}},
		{4{priority_level_b[3]}}, {4{priority_level_b[5]}},
		{3{priority_level_b[6]}}, {3{priority_level_b[7]}},
		{3{priority_level_a[0]}}, {3{priority_level_a[1]}},
		{3{priority_level_a[2]}}, {2{priority_level_a[3]}},
		priority_level_a[4], priority_level_a[4], priority_level_a[5],
		priority_level_a[5], priority_level_a[6], priority_level_a[7]}; // RULE13
	wire allow_lo = ~ccr_global_mask; // RULE14
	wire allow_hi = ~ccr_global_mask | (~ue & ~user_mask_bit); // RULE14 RULE24
	wire bus_take = hsel & htrans[1] & hready;
	wire wr_hit = bus_pend & bus_write & bus_ok;
	wire flags_wr = wr_hit && bus_idx == `IDX_IRQ_REQUEST_FLAGS;
	wire boundary = st[3] & cpu_insn_done; // RULE23
	wire [31:0] push_addr = stack_pointer - 32'h00000004;
	// Fixed order inside a level: lowest index, hence lowest vector, wins.
	always @* begin
		best_hi = 6'h00;
		best_lo = 6'h00;
		found_hi = 1'b0;
		found_lo = 1'b0;
		for (i = 35; i >= 0; i = i - 1) begin
			if (pend[i] && lvl[i]) begin
				found_hi = 1'b1;
				best_hi = i[5:0]; // RULE26
			end
			if (pend[i] && !lvl[i]) begin
				found_lo = 1'b1;
				best_lo = i[5:0]; // RULE26
			end
		end
		int_take = 1'b1;
		int_src = 6'h3f;
		if (nmi_flag) begin
			int_src = 6'h3f; // RULE12
		end else if (found_hi && allow_hi) begin
			int_src = best_hi; // RULE13
		end else if (found_lo && allow_lo) begin
			int_src = best_lo;
		end else begin
			int_take = 1'b0;
		end
	end
	// Edge-sensed pin flags are consumed when their interrupt is accepted.
	always @* begin
		ack_clear = 6'h00;
		if (boundary && int_take && !nmi_flag && int_src < 6'h06) begin
			ack_clear[int_src[2:0]] = irq_sense_control[int_src[2:0]];
		end
	end
	always @* begin
		case (bus_idx)
		`IDX_SYSTEM_CONTROL: rd_val = system_control;
		`IDX_IRQ_SENSE_CONTROL: rd_val = irq_sense_control;
		`IDX_IRQ_ENABLE: rd_val = irq_enable;
		`IDX_IRQ_REQUEST_FLAGS: rd_val = {2'b00, irq_request_flags};
		`IDX_PRIORITY_LEVEL_A: rd_val = priority_level_a;
		`IDX_PRIORITY_LEVEL_B: rd_val = priority_level_b;
		default: rd_val = 8'h00;
		endcase
	end
	// Every access gets one wait state so a read always sees the previous write.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hrdata <= 32'h00000000;
			hresp <= 1'b0;
			bus_pend <= 1'b0;
			bus_write <= 1'b0;
			bus_idx <= 16'h0000;
			bus_ok <= 1'b0;
		end else if (bus_pend) begin
			bus_pend <= 1'b0;
			hreadyout <= 1'b1;
			hrdata <= (!bus_write && bus_ok) ? {24'h000000, rd_val} : 32'h00000000;
		end else if (bus_take) begin
			bus_pend <= 1'b1;
			hreadyout <= 1'b0;
			bus_write <= hwrite;
			bus_idx <= haddr[17:2];
			bus_ok <= haddr[31:18] == 14'h0000 && haddr[1:0] == 2'b00;
		end
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			system_control <= `RST_SYSTEM_CONTROL; // RULE24 RULE25
			irq_sense_control <= `RST_IRQ_SENSE_CONTROL;
			irq_enable <= `RST_IRQ_ENABLE;
			priority_level_a <= `RST_PRIORITY_LEVEL_A;
			priority_level_b <= `RST_PRIORITY_LEVEL_B;
		end else if (reinit) begin
			system_control <= `RST_SYSTEM_CONTROL; // RULE3 RULE6
			irq_sense_control <= `RST_IRQ_SENSE_CONTROL;
			irq_enable <= `RST_IRQ_ENABLE;
			priority_level_a <= `RST_PRIORITY_LEVEL_A;
			priority_level_b <= `RST_PRIORITY_LEVEL_B;
		end else if (wr_hit) begin
			case (bus_idx)
			`IDX_SYSTEM_CONTROL: system_control <= hwdata[7:0];
			`IDX_IRQ_SENSE_CONTROL: irq_sense_control <= hwdata[7:0];
			`IDX_IRQ_ENABLE: irq_enable <= hwdata[7:0];
			`IDX_PRIORITY_LEVEL_A: priority_level_a <= hwdata[7:0];
			`IDX_PRIORITY_LEVEL_B: priority_level_b <= hwdata[7:0];
			default: system_control <= system_control;
			endcase
		end
	end
	// Request sources; a new event in the clearing cycle keeps its flag.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_request_flags <= 6'h00;
			nmi_prev <= 1'b0;
			nmi_flag <= 1'b0;
			pins_prev <= 6'h3f;
			wdt_flag <= 1'b0;
			ref_flag <= 1'b0;
		end else if (reinit) begin
			irq_request_flags <= 6'h00;
			nmi_prev <= nmi_pin;
			nmi_flag <= 1'b0;
			pins_prev <= ext_request_pins_n;
			wdt_flag <= 1'b0;
			ref_flag <= 1'b0;
		end else begin
			nmi_prev <= nmi_pin;
			pins_prev <= ext_request_pins_n;
			irq_request_flags <= pin_set | (irq_request_flags & ~ack_clear &
				~(flags_wr ? ~hwdata[5:0] : 6'h00)); // RULE20
			nmi_flag <= nmi_edge | (nmi_flag & ~(boundary & int_take)); // RULE12
			wdt_flag <= watchdog_interval_tick |
				(wdt_flag & ~(boundary & ~nmi_flag & int_take & int_src == 6'h06)); // RULE21
			ref_flag <= refresh_match_tick |
				(ref_flag & ~(boundary & ~nmi_flag & int_take & int_src == 6'h07)); // RULE21
		end
	end
	// Exception entry sequencer.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st <= ST_RVEC; // RULE2
			hold_cnt <= 4'h0;
			core_hold <= 1'b1; // RULE1
			ccr_global_mask <= 1'b1; // RULE6
			user_mask_bit <= 1'b0;
			pc_load <= 1'b0;
			pc_value <= 24'h000000;
			sp_load <= 1'b0;
			sp_value <= 32'h00000000;
			vector_number <= `VEC_RESET;
			mem_req <= 1'b0;
			mem_we <= 1'b0;
			mem_addr <= `RESET_VECTOR_ADDR; // RULE7
			mem_wdata <= 32'h00000000;
			trap_pend <= 1'b0;
			trap_vec <= 2'b00;
		end else begin
			pc_load <= 1'b0;
			sp_load <= 1'b0;
			if (cpu_trap && st[3]) begin
				trap_pend <= 1'b1;
				trap_vec <= cpu_trap_vec;
			end
			if (ccr_wr && (st[2] || st[3])) begin
				ccr_global_mask <= ccr_wdata[`CCR_GLOBAL_MASK];
				user_mask_bit <= ccr_wdata[`CCR_USER_MASK];
			end
			if (watchdog_overflow) begin
				st <= ST_HOLD; // RULE3
				hold_cnt <= `RST_HOLD_CYCLES;
				core_hold <= 1'b1;
				mem_req <= 1'b0;
				trap_pend <= 1'b0;
			end else begin
				case (st)
				ST_HOLD: begin
					core_hold <= 1'b1; // RULE1
					if (hold_cnt == 4'h1) begin
						st <= ST_RVEC;
						ccr_global_mask <= 1'b1; // RULE6
						user_mask_bit <= 1'b0;
						vector_number <= `VEC_RESET;
						mem_addr <= `RESET_VECTOR_ADDR; // RULE7
						mem_we <= 1'b0;
					end
					hold_cnt <= hold_cnt - 4'h1;
				end
				ST_RVEC, ST_VEC: begin
					if (!mem_req) begin
						mem_req <= 1'b1;
					end else if (mem_ack) begin
						mem_req <= 1'b0;
						pc_load <= 1'b1; // RULE7 RULE22
						pc_value <= mem_rdata[23:0];
						core_hold <= 1'b0;
						st <= st[1] ? ST_FIRST : ST_RUN; // RULE8
					end
				end
				ST_FIRST: begin
					if (cpu_insn_done) begin
						st <= ST_RUN; // RULE8
					end
				end
				ST_RUN: begin
					if (boundary && (int_take || trap_pend || cpu_trap)) begin
						st <= ST_PUSH; // RULE22 RULE23
						core_hold <= 1'b1;
						mem_we <= 1'b1;
						mem_addr <= {push_addr[23:1], 1'b0}; // RULE18
						sp_value <= {push_addr[31:1], 1'b0}; // RULE18
						mem_wdata <= {ccr_global_mask, user_mask_bit, ccr_low, program_counter};
						if (int_take) begin
							vector_number <= nmi_flag ? `VEC_NONMASKABLE :
								(int_src < 6'h06 ? `VEC_EXT_BASE + int_src :
								`VEC_INT_BASE + int_src - 6'h06); // RULE11
						end else begin
							trap_pend <= trap_pend & cpu_trap;
							vector_number <= `VEC_TRAP_BASE +
								{4'h0, trap_pend ? trap_vec : cpu_trap_vec}; // RULE17
						end
					end
				end
				ST_PUSH: begin
					if (!mem_req) begin
						mem_req <= 1'b1;
					end else if (mem_ack) begin
						mem_req <= 1'b0;
						mem_we <= 1'b0;
						sp_load <= 1'b1;
						ccr_global_mask <= 1'b1; // RULE16 RULE22
						if (!ue) begin
							user_mask_bit <= 1'b1; // RULE16
						end
						mem_addr <= {16'h0000, vector_number, 2'b00}; // RULE11
						st <= ST_VEC;
					end
				end
				default: begin
					st <= ST_HOLD;
					hold_cnt <= `RST_HOLD_CYCLES;
				end
				endcase
			end
		end
	end

endmodule

// [exc_entry_asserts.sv]
`timescale 1ns/10ps
module exc_checker (
	// Clock, reset and bus
	input logic hclk,
	input logic hresetn,
	input logic hsel,
	input logic [1:0] htrans,
	input logic hready,
	input logic hreadyout,
	// Core and memory side
	input logic watchdog_overflow,
	input logic cpu_insn_done,
	input logic core_hold,
	input logic ccr_global_mask,
	input logic pc_load,
	input logic [23:0] pc_value,
	input logic sp_load,
	input logic [5:0] vector_number,
	input logic mem_req,
	input logic mem_we,
	input logic [23:0] mem_addr,
	input logic mem_ack,
	input logic [31:0] mem_rdata
);
	logic seen_insn;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// A watchdog reset does not clear this, so the check is weaker afterwards, never wrong.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			seen_insn <= 1'b0;
		else if (cpu_insn_done)
			seen_insn <= 1'b1;
	end
	chk_reset_hold: assert property (disable iff (1'b0) !hresetn |-> core_hold && ccr_global_mask && !mem_req)
		else $error("core not held in reset");
	chk_bus_answer: assert property (hsel && htrans[1] && hready |=> !hreadyout ##1 hreadyout)
		else $error("bus answer timing wrong");
	chk_early_push: assert property (!seen_insn |-> !(mem_req && mem_we))
		else $error("entry before first instruction");
	chk_push_even: assert property (mem_req && mem_we |-> !mem_addr[0])
		else $error("odd stack address");
	chk_vec_read: assert property (mem_req && !mem_we |-> mem_addr == {16'h0, vector_number, 2'h0})
		else $error("vector address wrong");
	chk_pc_vector: assert property (mem_req && !mem_we && mem_ack |=> pc_load && !core_hold && pc_value == $past(mem_rdata[23:0]))
		else $error("start address not taken from vector");
	chk_entry_mask: assert property (sp_load |-> ccr_global_mask)
		else $error("mask not set on entry");
	chk_mem_stall: assert property (mem_req && !mem_ack && !watchdog_overflow |=> mem_req && $stable(mem_addr))
		else $error("memory request dropped");
	cover property (sp_load && vector_number == 6'h07);
	cover property (pc_load && vector_number[5:2] == 4'h2);
	cover property (hsel && htrans[1] && hready);
endmodule
bind reset_trap_interrupt_entry exc_checker u_chk (.hclk, .hresetn, .hsel, .htrans, .hready,
	.hreadyout, .watchdog_overflow, .cpu_insn_done, .core_hold, .ccr_global_mask, .pc_load,
	.pc_value, .sp_load, .vector_number, .mem_req, .mem_we, .mem_addr, .mem_ack, .mem_rdata);

// [exc_mem_partner.sv]
`timescale 1ns/10ps
module mem_partner (
	// Clock
	input logic hclk,
	// Memory port
	input logic mem_req,
	input logic mem_we,
	input logic [23:0] mem_addr,
	input logic [31:0] mem_wdata,
	output logic mem_ack = 1'b0,
	output logic [31:0] mem_rdata = 32'h0,
	// Last stacked word
	output logic [23:0] last_waddr = 24'h0,
	output logic [31:0] last_wdata = 32'h0
);
	logic [1:0] cnt = 2'h0;
	logic [1:0] slow = 2'h0;
	// Answers alternate between prompt and three cycles late; read data toggles when idle
	// so a late sample is never mistaken for a vector.
	always @(posedge hclk) begin
		mem_ack <= 1'b0;
		mem_rdata <= ~mem_rdata;
		if (mem_req && !mem_ack) begin
			if (cnt == slow) begin
				mem_ack <= 1'b1;
				mem_rdata <= {8'h00, mem_addr + 24'h000100};
				cnt <= 2'h0;
				slow <= slow ^ 2'h3;
				if (mem_we) begin
					last_waddr <= mem_addr;
					last_wdata <= mem_wdata;
				end
			end else
				cnt <= cnt + 2'h1;
		end
	end
endmodule

// [testbench.sv]
`timescale 1ns/10ps
`include "exc_entry_defs.vh"
module testbench;
	logic hclk = 1'b0;
	logic hresetn = 1'b1;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic nmi_pin = 1'b1;
	logic [5:0] ext_request_pins_n = 6'h3f;
	logic watchdog_overflow = 1'b0;
	logic watchdog_interval_tick = 1'b0;
	logic refresh_match_tick = 1'b0;
	logic cpu_insn_done = 1'b0;
	logic cpu_trap = 1'b0;
	logic [1:0] cpu_trap_vec = 2'h0;
	logic ccr_wr = 1'b0;
	logic [7:0] ccr_wdata = 8'h0;
	logic [5:0] ccr_low = 6'h15;
	logic [23:0] program_counter = 24'h001234;
	logic [31:0] stack_pointer = 32'h0000fff0;
	wire hreadyout, hresp, core_hold, ccr_global_mask, user_mask_bit, pc_load, sp_load;
	wire mem_req, mem_we, mem_ack;
	wire [31:0] hrdata, sp_value, mem_wdata, mem_rdata, last_wdata;
	wire [23:0] pc_value, mem_addr, last_waddr;
	wire [5:0] vector_number;
	logic [31:0] rd;
	int n_fail = 0;
	int n_tests = 0;
	int cyc = 0;
	always #5 hclk = ~hclk;
	reset_trap_interrupt_entry u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
		.hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .nmi_pin,
		.ext_request_pins_n, .watchdog_overflow, .watchdog_interval_tick,
		.refresh_match_tick, .periph_req(28'h0), .cpu_insn_done, .cpu_trap, .cpu_trap_vec,
		.ccr_wr, .ccr_wdata, .ccr_low, .program_counter, .stack_pointer, .core_hold,
		.ccr_global_mask, .user_mask_bit, .pc_load, .pc_value, .sp_load, .sp_value,
		.vector_number, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata);
	mem_partner u_mem (.hclk, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata,
		.last_waddr, .last_wdata);
	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task bus(input logic wr, input logic [15:0] idx, input logic [7:0] wd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {14'h0, idx, 2'h0};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, wd};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task rchk(input string nm, input logic [15:0] idx, input logic [7:0] exp);
		bus(1'b0, idx, 8'h00);
		chk(nm, {24'h0, exp}, rd);
	endtask
	task condition_flags_reg(input logic [7:0] v);
		ccr_wr <= 1'b1;
		ccr_wdata <= v;
		@(posedge hclk);
		ccr_wr <= 1'b0;
	endtask
	task bnd(input logic tr, input logic [1:0] n);
		cpu_insn_done <= 1'b1;
		cpu_trap <= tr;
		cpu_trap_vec <= n;
		@(posedge hclk);
		cpu_insn_done <= 1'b0;
		cpu_trap <= 1'b0;
	endtask
	task pulse_pins(input logic [5:0] low);
		ext_request_pins_n <= ~low;
		@(posedge hclk);
		ext_request_pins_n <= 6'h3f;
	endtask
	task wait_pc(input logic [5:0] v);
		int t;
		t = 0;
		do begin
			@(posedge hclk);
			t++;
		end while (pc_load !== 1'b1 && t < 60);
		chk("entry", 32'h1, {31'h0, pc_load});
		chk("vector", {26'h0, v}, {26'h0, vector_number});
		chk("start", {24'h0, v, 2'h0} + 32'h100, {8'h0, pc_value});
	endtask
	task finish_test;
		$display("checks %0d failures %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 6000) begin
			n_fail++;
			finish_test;
		end
	end
	initial begin
		// The power-up hold is cut short to keep the run small; the reset is level-driven.
		hresetn <= 1'b0;
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		wait_pc(`VEC_RESET);
		chk("global mask", 32'h1, {31'h0, ccr_global_mask});
		rchk("sysctl", `IDX_SYSTEM_CONTROL, `RST_SYSTEM_CONTROL);
		rchk("sense", `IDX_IRQ_SENSE_CONTROL, `RST_IRQ_SENSE_CONTROL);
		rchk("enable", `IDX_IRQ_ENABLE, `RST_IRQ_ENABLE);
		rchk("flags", `IDX_IRQ_REQUEST_FLAGS, `RST_IRQ_REQUEST_FLAGS);
		rchk("prio a", `IDX_PRIORITY_LEVEL_A, `RST_PRIORITY_LEVEL_A);
		rchk("prio b", `IDX_PRIORITY_LEVEL_B, `RST_PRIORITY_LEVEL_B);
		rchk("unmapped", 16'hfff3, 8'h00);
		chk("hresp", 32'h0, {31'h0, hresp});
		nmi_pin <= 1'b0;
		repeat (6) @(posedge hclk);
		chk("early entry", 32'h0, {31'h0, mem_req});
		bnd(1'b0, 2'h0);
		// The first instruction ends outside the run state, so the request waits for a second.
		@(posedge hclk);
		bnd(1'b0, 2'h0);
		wait_pc(`VEC_NONMASKABLE);
		chk("push addr", 32'h0000ffec, {8'h0, last_waddr});
		chk("push data", 32'h95001234, last_wdata);
		chk("new sp", 32'h0000ffec, sp_value);
		nmi_pin <= 1'b1;
		for (int n = 0; n < 4; n++) begin
			bus(1'b1, `IDX_SYSTEM_CONTROL, n[0] ? 8'h0b : 8'h03);
			condition_flags_reg(8'h00);
			bnd(1'b1, n[1:0]);
			wait_pc(`VEC_TRAP_BASE + n[5:0]);
			chk("trap i", 32'h1, {31'h0, ccr_global_mask});
			chk("trap ui", {31'h0, ~n[0]}, {31'h0, user_mask_bit});
		end
		bus(1'b1, `IDX_SYSTEM_CONTROL, 8'h07);
		nmi_pin <= 1'b0;
		@(posedge hclk);
		nmi_pin <= 1'b1;
		@(posedge hclk);
		bnd(1'b0, 2'h0);
		wait_pc(`VEC_NONMASKABLE);
		condition_flags_reg(8'hc0);
		bus(1'b1, `IDX_IRQ_SENSE_CONTROL, 8'h03);
		pulse_pins(6'h03);
		rchk("edge flags", `IDX_IRQ_REQUEST_FLAGS, 8'h03);
		bus(1'b1, `IDX_IRQ_REQUEST_FLAGS, 8'hfe);
		rchk("zero clears", `IDX_IRQ_REQUEST_FLAGS, 8'h02);
		bus(1'b1, `IDX_IRQ_REQUEST_FLAGS, 8'hff);
		rchk("one keeps", `IDX_IRQ_REQUEST_FLAGS, 8'h02);
		ext_request_pins_n <= 6'h3b;
		rchk("level flag", `IDX_IRQ_REQUEST_FLAGS, 8'h06);
		ext_request_pins_n <= 6'h3f;
		bus(1'b1, `IDX_IRQ_REQUEST_FLAGS, 8'hfb);
		bus(1'b1, `IDX_PRIORITY_LEVEL_A, 8'h80);
		bus(1'b1, `IDX_IRQ_ENABLE, 8'h03);
		condition_flags_reg(8'h80);
		pulse_pins(6'h01);
		bnd(1'b0, 2'h0);
		wait_pc(`VEC_EXT_BASE);
		condition_flags_reg(8'h80);
		bnd(1'b0, 2'h0);
		repeat (8) @(posedge hclk);
		chk("masked level", {26'h0, `VEC_EXT_BASE}, {26'h0, vector_number});
		condition_flags_reg(8'h00);
		bnd(1'b0, 2'h0);
		wait_pc(`VEC_EXT_BASE + 6'h01);
		condition_flags_reg(8'h00);
		watchdog_interval_tick <= 1'b1;
		refresh_match_tick <= 1'b1;
		@(posedge hclk);
		watchdog_interval_tick <= 1'b0;
		refresh_match_tick <= 1'b0;
		bnd(1'b0, 2'h0);
		wait_pc(`VEC_INT_BASE);
		condition_flags_reg(8'h00);
		bnd(1'b0, 2'h0);
		wait_pc(`VEC_INT_BASE + 6'h01);
		bus(1'b1, `IDX_IRQ_ENABLE, 8'h3f);
		watchdog_overflow <= 1'b1;
		@(posedge hclk);
		watchdog_overflow <= 1'b0;
		wait_pc(`VEC_RESET);
		rchk("wdt enable", `IDX_IRQ_ENABLE, `RST_IRQ_ENABLE);
		finish_test;
	end
endmodule
